// *** core/psi_core.sv ***
// Program counter, return stack and indirect addressing unit
`timescale 1ns/1ns
`default_nettype none
module psi_core (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire psi_pkg::psi_seq_t seq,
   input wire psi_pkg::psi_ind_t ind,
   input wire logic [7:0] data_rdata,
   input wire logic [13:0] prog_rdata,
   output logic [14:0] pc_q,
   output logic [11:0] data_addr_q,
   output logic data_we_q,
   output logic [7:0] data_wdata_q,
   output logic [14:0] prog_addr_q,
   output logic [7:0] ind_rdata_q,
   output logic ind_done_q,
   output logic ind_stall_q,
   output logic stack_reset_q
);
   logic [14:0] pc_d;
   logic [6:0] latch_q;
   logic [14:0] stk_mem [psi_pkg::STK_DEPTH];
   logic [4:0] sp_q;
   logic fault_en_q;
   logic ovf_q;
   logic unf_q;
   logic [7:0] shadow_q [8];
   logic push;
   logic pop;
   logic [4:0] sp_inc;
   logic [4:0] sp_dec;
   logic [14:0] pc_inc;
   logic ap_valid;
   logic ap_wr_q;
   logic [11:0] ap_idx_q;
   logic [7:0] wb;
   psi_pkg::psi_ind_st_t ist_q;
   logic map_hit;
   logic [11:0] map_addr;
   logic ind_hit_q;
   logic ind_wr_q;

   function automatic logic [3:0] slot(input logic [4:0] p);
      slot = p[3:0];
   endfunction

   // Linear offset to bank base plus GPR offset
   function automatic logic [11:0] lin_map(input logic [15:0] a);
      logic [15:0] off;
      logic [15:0] bank;
      logic [15:0] rem;
      off = a - psi_pkg::LIN_FIRST;
      bank = off / 16'(psi_pkg::GPR_BYTES);
      rem = off % 16'(psi_pkg::GPR_BYTES);
      lin_map = 12'(bank * 16'(psi_pkg::BANK_SIZE) + 16'(psi_pkg::GPR_BASE) + rem);
   endfunction

   assign push = seq.op == psi_pkg::OP_CALL || seq.op == psi_pkg::OP_COMPUTED_CALL ||
      seq.op == psi_pkg::OP_IRQ;
   assign pop = seq.op == psi_pkg::OP_RET;
   assign sp_inc = 5'(sp_q + 5'h01);
   assign sp_dec = 5'(sp_q - 5'h01);
   assign pc_inc = 15'(pc_q + 15'h0001);
   assign ap_valid = hsel && hready && htrans == psi_pkg::HTRANS_NONSEQ;
   assign wb = hwdata[7:0];

   // Counter sequencing; instruction ops win over bus writes
   always_comb begin
      pc_d = pc_q;
      unique case (seq.op)
         psi_pkg::OP_PCL_WR: pc_d = {latch_q, seq.wreg};
         psi_pkg::OP_CALL: pc_d = {latch_q[6:3], seq.operand};
         psi_pkg::OP_COMPUTED_CALL: pc_d = {latch_q, seq.wreg};
         psi_pkg::OP_BRW: pc_d = 15'(pc_inc + {7'h00, seq.wreg});
         psi_pkg::OP_BRA: pc_d = 15'(pc_inc + {{6{seq.operand[8]}}, seq.operand[8:0]});
         psi_pkg::OP_IRQ: pc_d = {latch_q, seq.wreg};
         psi_pkg::OP_RET: pc_d = stk_mem[slot(sp_q)];
         psi_pkg::OP_NONE: begin
            if (ap_wr_q && ap_idx_q == psi_pkg::IDX_PCL) begin
               pc_d = {latch_q, wb};
            end else begin
               pc_d = pc_inc;
            end
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pc_q <= psi_pkg::PC_RST;
      end else if (stack_reset_q) begin
         pc_q <= psi_pkg::PC_RST;
      end else if (!ind_stall_q) begin
         pc_q <= pc_d;
      end
   end

   // Latch untouched by push and pop
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         latch_q <= 7'h00;
      end else if (ap_wr_q && ap_idx_q == psi_pkg::IDX_LATCH) begin
         latch_q <= wb[6:0];
      end
   end

   // Stack pointer
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sp_q <= psi_pkg::SP_RST;
      end else if (stack_reset_q) begin
         sp_q <= psi_pkg::SP_RST;
      end else if (push) begin
         sp_q <= (sp_q == psi_pkg::SP_TOP) ? 5'h00 : sp_inc;
      end else if (pop) begin
         sp_q <= (sp_q == psi_pkg::SP_EMPTY) ? psi_pkg::SP_EMPTY : sp_dec;
      end else if (ap_wr_q && ap_idx_q == psi_pkg::IDX_STACK_POINTER) begin
         sp_q <= wb[4:0];
      end
   end

   // Stack storage; no reset, contents unknown until pushed or written over the bus
   always_ff @(posedge hclk) begin
      if (push) begin
         stk_mem[slot(sp_inc)] <= pc_inc;
      end else if (ap_wr_q && ap_idx_q == psi_pkg::IDX_TOP_OF_STACK_LOW) begin
         stk_mem[slot(sp_q)][7:0] <= wb;
      end else if (ap_wr_q && ap_idx_q == psi_pkg::IDX_TOP_OF_STACK_HIGH) begin
         stk_mem[slot(sp_q)][14:8] <= wb[6:0];
      end
   end

   // Fault flags: set wins over software clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ovf_q <= 1'b0;
         unf_q <= 1'b0;
         fault_en_q <= 1'b0;
      end else begin
         if (ap_wr_q && ap_idx_q == psi_pkg::IDX_FLAGS) begin
            fault_en_q <= wb[psi_pkg::BIT_FAULT_EN];
         end
         if (push && sp_q == psi_pkg::SP_TOP) begin
            ovf_q <= 1'b1;
         end else if (ap_wr_q && ap_idx_q == psi_pkg::IDX_FLAGS) begin
            ovf_q <= wb[psi_pkg::BIT_OVF];
         end
         if (pop && sp_q == psi_pkg::SP_EMPTY) begin
            unf_q <= 1'b1;
         end else if (ap_wr_q && ap_idx_q == psi_pkg::IDX_FLAGS) begin
            unf_q <= wb[psi_pkg::BIT_UNF];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stack_reset_q <= 1'b0;
      end else begin
         stack_reset_q <= fault_en_q && ((push && sp_q == psi_pkg::SP_TOP) ||
            (pop && sp_q == psi_pkg::SP_EMPTY));
      end
   end

   // Shadow registers are plain storage
   always_ff @(posedge hclk) begin
      if (ap_wr_q && ap_idx_q >= psi_pkg::IDX_STATUS_SH && ap_idx_q <= psi_pkg::IDX_P1H_SH) begin
         shadow_q[3'(ap_idx_q - psi_pkg::IDX_STATUS_SH)] <= wb;
      end
   end

   // AHB-Lite: zero wait states, always OKAY
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_wr_q <= 1'b0;
         ap_idx_q <= 12'h000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         ap_wr_q <= ap_valid && hwrite;
         if (ap_valid) begin
            ap_idx_q <= haddr[13:2];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (ap_valid && !hwrite) begin
         hrdata <= 32'h0000_0000;
         if (haddr[13:2] >= psi_pkg::IDX_STATUS_SH && haddr[13:2] <= psi_pkg::IDX_P1H_SH) begin
            hrdata[7:0] <= shadow_q[3'(haddr[13:2] - psi_pkg::IDX_STATUS_SH)];
         end else begin
            unique case (haddr[13:2])
               psi_pkg::IDX_STACK_POINTER: hrdata[4:0] <= sp_q;
               psi_pkg::IDX_TOP_OF_STACK_LOW: hrdata[7:0] <= stk_mem[slot(sp_q)][7:0];
               psi_pkg::IDX_TOP_OF_STACK_HIGH: hrdata[6:0] <= stk_mem[slot(sp_q)][14:8];
               psi_pkg::IDX_PCL: hrdata[7:0] <= pc_q[7:0];
               psi_pkg::IDX_LATCH: hrdata[6:0] <= latch_q;
               psi_pkg::IDX_FLAGS: hrdata[2:0] <= {unf_q, ovf_q, fault_en_q};
               default: hrdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Indirect pointer decode
   always_comb begin
      map_hit = 1'b0;
      map_addr = 12'h000;
      if (ind.ptr <= psi_pkg::TRAD_LAST) begin
         map_hit = ind.ptr != psi_pkg::IND0_ADDR && ind.ptr != psi_pkg::IND1_ADDR;
         map_addr = ind.ptr[11:0];
      end else if (ind.ptr >= psi_pkg::LIN_FIRST && ind.ptr <= psi_pkg::LIN_LAST) begin
         map_hit = 1'b1;
         map_addr = lin_map(ind.ptr);
      end
   end

   // Indirect access sequencer
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ist_q <= psi_pkg::IND_IDLE;
         ind_done_q <= 1'b0;
         ind_stall_q <= 1'b0;
         ind_rdata_q <= 8'h00;
         data_addr_q <= 12'h000;
         data_we_q <= 1'b0;
         data_wdata_q <= 8'h00;
         prog_addr_q <= 15'h0000;
         ind_hit_q <= 1'b0;
         ind_wr_q <= 1'b0;
      end else begin
         ind_done_q <= 1'b0;
         data_we_q <= 1'b0;
         unique case (ist_q)
            psi_pkg::IND_IDLE: begin
               // Request is a one-cycle pulse, so hit and direction are kept
               if (ind.req && ind.ptr[psi_pkg::PROG_BIT]) begin
                  prog_addr_q <= ind.ptr[14:0];
                  ind_wr_q <= ind.wr;
                  ind_stall_q <= 1'b1;
                  ist_q <= psi_pkg::IND_PROG;
               end else if (ind.req) begin
                  data_addr_q <= map_addr;
                  data_we_q <= ind.wr && map_hit;
                  data_wdata_q <= ind.wdata;
                  ind_hit_q <= map_hit;
                  ind_stall_q <= 1'b0;
                  ist_q <= psi_pkg::IND_DONE;
               end
            end
            psi_pkg::IND_PROG: begin
               ind_rdata_q <= ind_wr_q ? 8'h00 : prog_rdata[7:0];
               ind_stall_q <= 1'b0;
               ind_done_q <= 1'b1;
               ist_q <= psi_pkg::IND_IDLE;
            end
            psi_pkg::IND_DONE: begin
               ind_rdata_q <= ind_hit_q ? data_rdata : 8'h00;
               ind_done_q <= 1'b1;
               ist_q <= psi_pkg::IND_IDLE;
            end
            default: ist_q <= psi_pkg::IND_IDLE;
         endcase
      end
   end

   AST_CALL_PUSH: assert property (@(posedge hclk) disable iff (!hresetn)
      seq.op == psi_pkg::OP_CALL && !stack_reset_q && !ind_stall_q
      |=> pc_q == {$past(latch_q[6:3]), $past(seq.operand)})
      else $error("call target wrong");
   AST_PCL_WR: assert property (@(posedge hclk) disable iff (!hresetn)
      seq.op == psi_pkg::OP_PCL_WR && !stack_reset_q && !ind_stall_q
      |=> pc_q == {$past(latch_q), $past(seq.wreg)})
      else $error("low byte write target wrong");
   AST_COMPUTED_CALL: assert property (@(posedge hclk) disable iff (!hresetn)
      seq.op == psi_pkg::OP_COMPUTED_CALL && !stack_reset_q && !ind_stall_q
      |=> pc_q == {$past(latch_q), $past(seq.wreg)})
      else $error("computed call target wrong");
   AST_BRW: assert property (@(posedge hclk) disable iff (!hresetn)
      seq.op == psi_pkg::OP_BRW && !stack_reset_q && !ind_stall_q
      |=> pc_q == 15'($past(pc_q) + 15'h0001 + {7'h00, $past(seq.wreg)}))
      else $error("register branch wrong");
   AST_BRA: assert property (@(posedge hclk) disable iff (!hresetn)
      seq.op == psi_pkg::OP_BRA && !stack_reset_q && !ind_stall_q
      |=> pc_q == 15'($past(pc_q) + 15'h0001 + {{6{$past(seq.operand[8])}}, $past(seq.operand[8:0])}))
      else $error("immediate branch wrong");
   AST_SP_PUSH: assert property (@(posedge hclk) disable iff (!hresetn)
      push && !stack_reset_q && sp_q != psi_pkg::SP_TOP |=> sp_q == 5'($past(sp_q) + 5'h01))
      else $error("push pointer wrong");
   AST_SP_POP: assert property (@(posedge hclk) disable iff (!hresetn)
      pop && !push && !stack_reset_q && sp_q != psi_pkg::SP_EMPTY
      |=> sp_q == 5'($past(sp_q) - 5'h01))
      else $error("pop pointer wrong");
   AST_POP_EMPTY: assert property (@(posedge hclk) disable iff (!hresetn)
      pop && !stack_reset_q && sp_q == psi_pkg::SP_EMPTY |=> sp_q == psi_pkg::SP_EMPTY)
      else $error("empty pop moved pointer");
   AST_OVF: assert property (@(posedge hclk) disable iff (!hresetn)
      push && sp_q == psi_pkg::SP_TOP |=> ovf_q)
      else $error("overflow flag missed");
   AST_UNF: assert property (@(posedge hclk) disable iff (!hresetn)
      pop && sp_q == psi_pkg::SP_EMPTY |=> unf_q)
      else $error("underflow flag missed");
   AST_FAULT_RST: assert property (@(posedge hclk) disable iff (!hresetn)
      stack_reset_q |=> pc_q == psi_pkg::PC_RST && sp_q == psi_pkg::SP_RST)
      else $error("stack fault reset missing");
   AST_PROG_EXTRA: assert property (@(posedge hclk) disable iff (!hresetn)
      ist_q == psi_pkg::IND_IDLE && ind.req && ind.ptr[psi_pkg::PROG_BIT]
      |=> ind_stall_q ##1 ind_done_q)
      else $error("program access timing wrong");
   AST_IND_SELF: assert property (@(posedge hclk) disable iff (!hresetn)
      ist_q == psi_pkg::IND_IDLE && ind.req && ind.ptr <= psi_pkg::IND1_ADDR
      |=> !data_we_q ##1 ind_rdata_q == 8'h00)
      else $error("self access not blocked");
endmodule
`default_nettype wire

// *** core/psi_pkg.sv ***
// Constants and carriers for the program-flow and addressing unit
`default_nettype none
package psi_pkg;
   localparam int PC_W = 15;
   localparam int SP_W = 5;
   localparam int STK_DEPTH = 16;
   localparam logic [PC_W-1:0] PC_RST = 15'h0000;
   localparam logic [SP_W-1:0] SP_RST = 5'h1f;
   localparam logic [SP_W-1:0] SP_TOP = 5'h0f;
   localparam logic [SP_W-1:0] SP_EMPTY = 5'h1f;
   // Register indices; the bus byte address is four times the index
   localparam logic [11:0] IDX_STATUS_SH = 12'hfe4;
   localparam logic [11:0] IDX_WORK_SH = 12'hfe5;
   localparam logic [11:0] IDX_BANK_SH = 12'hfe6;
   localparam logic [11:0] IDX_LATCH_SH = 12'hfe7;
   localparam logic [11:0] IDX_P0L_SH = 12'hfe8;
   localparam logic [11:0] IDX_P0H_SH = 12'hfe9;
   localparam logic [11:0] IDX_P1L_SH = 12'hfea;
   localparam logic [11:0] IDX_P1H_SH = 12'hfeb;
   localparam logic [11:0] IDX_STACK_POINTER = 12'hfed;
   localparam logic [11:0] IDX_TOP_OF_STACK_LOW = 12'hfee;
   localparam logic [11:0] IDX_TOP_OF_STACK_HIGH = 12'hfef;
   // Own registers
   localparam logic [11:0] IDX_PCL = 12'hf00;
   localparam logic [11:0] IDX_LATCH = 12'hf01;
   localparam logic [11:0] IDX_FLAGS = 12'hf02;
   localparam int BIT_FAULT_EN = 0;
   localparam int BIT_OVF = 1;
   localparam int BIT_UNF = 2;
   // Indirect map
   localparam logic [15:0] IND0_ADDR = 16'h0000;
   localparam logic [15:0] IND1_ADDR = 16'h0001;
   localparam logic [15:0] TRAD_LAST = 16'h0fff;
   localparam logic [15:0] LIN_FIRST = 16'h2000;
   localparam logic [15:0] LIN_LAST = 16'h29af;
   localparam logic [6:0] GPR_BYTES = 7'h50;
   localparam logic [6:0] GPR_BASE = 7'h20;
   localparam logic [7:0] BANK_SIZE = 8'h80;
   localparam int PROG_BIT = 15;
   localparam logic [2:0] OP_NONE = 3'h0;
   localparam logic [2:0] OP_PCL_WR = 3'h1;
   localparam logic [2:0] OP_CALL = 3'h2;
   localparam logic [2:0] OP_COMPUTED_CALL = 3'h3;
   localparam logic [2:0] OP_BRW = 3'h4;
   localparam logic [2:0] OP_BRA = 3'h5;
   localparam logic [2:0] OP_IRQ = 3'h6;
   localparam logic [2:0] OP_RET = 3'h7;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

   typedef struct packed {
      logic [2:0] op;
      logic [10:0] operand;
      logic [7:0] wreg;
   } psi_seq_t;

   typedef struct packed {
      logic req;
      logic wr;
      logic [15:0] ptr;
      logic [7:0] wdata;
   } psi_ind_t;

   typedef enum logic [1:0] {
      IND_IDLE = 2'b00,
      IND_PROG = 2'b01,
      IND_DONE = 2'b10
   } psi_ind_st_t;
endpackage
`default_nettype wire

// *** sim/psi_core_tb.sv ***
// Self-checking bench for the program-flow and addressing unit
`timescale 1ns/1ns
`default_nettype none
module psi_core_tb;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   psi_pkg::psi_seq_t seq = '0;
   psi_pkg::psi_ind_t ind = '0;
   logic [7:0] data_rdata = 8'h0;
   logic [13:0] prog_rdata = 14'h0;
   wire logic hready;
   logic [31:0] hrdata;
   logic hreadyout, hresp, data_we_q, ind_done_q, ind_stall_q, stack_reset_q;
   logic [14:0] pc_q, prog_addr_q;
   logic [11:0] data_addr_q;
   logic [7:0] data_wdata_q, ind_rdata_q, r;
   logic [14:0] p, a, b;
   int errors = 0;
   int num_checks = 0;
   int cyc = 0;
   int rst_pulses = 0;

   // Single slave, so its ready is the bus ready
   assign hready = hreadyout;
   always #5 hclk = ~hclk;

   psi_core u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .seq(seq), .ind(ind),
      .data_rdata(data_rdata), .prog_rdata(prog_rdata), .pc_q(pc_q),
      .data_addr_q(data_addr_q), .data_we_q(data_we_q), .data_wdata_q(data_wdata_q),
      .prog_addr_q(prog_addr_q), .ind_rdata_q(ind_rdata_q), .ind_done_q(ind_done_q),
      .ind_stall_q(ind_stall_q), .stack_reset_q(stack_reset_q));

   // Ceiling well above the few hundred cycles the run needs
   always @(posedge hclk) begin
      cyc++;
      if (stack_reset_q === 1'b1) begin
         rst_pulses++;
      end
      if (cyc == 20000) begin
         errors++;
         test_done();
      end
   end

   task automatic test_done();
      $display("checks=%0d errors=%0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic bus(input logic w, input logic [11:0] idx, input logic [7:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= psi_pkg::HTRANS_NONSEQ;
      hwrite <= w;
      haddr <= {18'h0, idx, 2'h0};
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, wd};
      do @(posedge hclk); while (hready !== 1'b1);
      r = hrdata[7:0];
      chk(hresp, 1'b0);
   endtask

   task automatic wr(input logic [11:0] idx, input logic [7:0] d);
      bus(1'b1, idx, d);
   endtask

   task automatic rc(input logic [11:0] idx, input logic [7:0] e);
      bus(1'b0, idx, 8'h0);
      chk(r, e);
   endtask

   // Counter value feeding the op is caught in p
   task automatic seq_op(input logic [2:0] o, input logic [10:0] v, input logic [7:0] w);
      @(posedge hclk);
      seq <= '{o, v, w};
      #1 p = pc_q;
      @(posedge hclk);
      seq <= '0;
      #1;
   endtask

   // Address check skipped when adr is 7fff, stall check when st_exp is negative
   task automatic indr(input logic w, input logic [15:0] ptr, input logic [7:0] wd,
         input logic [7:0] erd, input logic we_exp, input logic [14:0] adr, input int st_exp);
      int n;
      int st;
      logic we;
      logic [7:0] wv;
      logic [14:0] ad;
      n = 0;
      st = 0;
      we = 1'b0;
      wv = ~wd;
      @(posedge hclk);
      ind <= '{1'b1, w, ptr, wd};
      // Request is taken at this edge; outputs are looked at from here on
      @(posedge hclk);
      ind <= '0;
      do begin
         if (n > 0) @(posedge hclk);
         #1 n++;
         if (data_we_q === 1'b1) begin
            we = 1'b1;
            wv = data_wdata_q;
         end
         if (ind_stall_q === 1'b1) begin
            st++;
         end
         if (n == 1) begin
            ad = ptr[15] ? prog_addr_q : {3'h0, data_addr_q};
         end
      end while (ind_done_q !== 1'b1 && n < 8);
      chk(n, 2);
      if (!w) chk(ind_rdata_q, erd);
      chk(we, we_exp);
      if (we_exp) chk(wv, wd);
      if (adr != 15'h7fff) chk(ad, adr);
      if (st_exp >= 0) chk(st, st_exp);
   endtask

   task automatic t_reset();
      repeat (4) @(posedge hclk);
      #1 chk(pc_q, 15'h0);
      @(posedge hclk);
      hresetn <= 1'b1;
      rc(psi_pkg::IDX_STACK_POINTER, 8'h1f);
   endtask

   task automatic t_flow();
      wr(psi_pkg::IDX_LATCH, 8'h55);
      seq_op(psi_pkg::OP_PCL_WR, 11'h0, 8'ha3);
      chk(pc_q, 15'h55a3);
      wr(psi_pkg::IDX_PCL, 8'h77);
      #1 chk(pc_q, 15'h5577);
      seq_op(psi_pkg::OP_CALL, 11'h123, 8'h0);
      a = p + 15'h1;
      chk(pc_q, 15'h5123);
      rc(psi_pkg::IDX_STACK_POINTER, 8'h00);
      rc(psi_pkg::IDX_TOP_OF_STACK_LOW, a[7:0]);
      rc(psi_pkg::IDX_TOP_OF_STACK_HIGH, {1'b0, a[14:8]});
      seq_op(psi_pkg::OP_COMPUTED_CALL, 11'h0, 8'h44);
      b = p + 15'h1;
      chk(pc_q, 15'h5544);
      seq_op(psi_pkg::OP_BRW, 11'h0, 8'hff);
      chk(pc_q, p + 15'h100);
      seq_op(psi_pkg::OP_BRA, 11'h1f0, 8'h0);
      chk(pc_q, p - 15'hf);
      seq_op(psi_pkg::OP_BRA, 11'h0ff, 8'h0);
      chk(pc_q, p + 15'h100);
      seq_op(psi_pkg::OP_RET, 11'h0, 8'h0);
      chk(pc_q, b);
      seq_op(psi_pkg::OP_RET, 11'h0, 8'h0);
      chk(pc_q, a);
      rc(psi_pkg::IDX_LATCH, 8'h55);
      seq_op(psi_pkg::OP_IRQ, 11'h0, 8'h10);
      chk(pc_q, 15'h5510);
      seq_op(psi_pkg::OP_RET, 11'h0, 8'h0);
   endtask

   task automatic t_stack();
      wr(psi_pkg::IDX_FLAGS, 8'h00);
      for (int i = 0; i < 17; i++) begin
         seq_op(psi_pkg::OP_CALL, 11'(i), 8'h0);
         if (i == 15) rc(psi_pkg::IDX_STACK_POINTER, 8'h0f);
      end
      a = p + 15'h1;
      rc(psi_pkg::IDX_STACK_POINTER, 8'h00);
      rc(psi_pkg::IDX_TOP_OF_STACK_LOW, a[7:0]);
      rc(psi_pkg::IDX_FLAGS, 8'h02);
      wr(psi_pkg::IDX_FLAGS, 8'h00);
      wr(psi_pkg::IDX_STACK_POINTER, 8'h1f);
      seq_op(psi_pkg::OP_RET, 11'h0, 8'h0);
      rc(psi_pkg::IDX_FLAGS, 8'h04);
      rc(psi_pkg::IDX_STACK_POINTER, 8'h1f);
      chk(rst_pulses, 0);
      wr(psi_pkg::IDX_FLAGS, 8'h01);
      wr(psi_pkg::IDX_STACK_POINTER, 8'h0f);
      seq_op(psi_pkg::OP_CALL, 11'h0, 8'h0);
      rc(psi_pkg::IDX_FLAGS, 8'h03);
      chk(rst_pulses, 1);
      wr(psi_pkg::IDX_FLAGS, 8'h01);
      wr(psi_pkg::IDX_STACK_POINTER, 8'h1f);
      seq_op(psi_pkg::OP_RET, 11'h0, 8'h0);
      rc(psi_pkg::IDX_FLAGS, 8'h05);
      chk(rst_pulses, 2);
      wr(psi_pkg::IDX_FLAGS, 8'h00);
      wr(psi_pkg::IDX_STACK_POINTER, 8'h03);
      wr(psi_pkg::IDX_TOP_OF_STACK_LOW, 8'h34);
      wr(psi_pkg::IDX_TOP_OF_STACK_HIGH, 8'h12);
      rc(psi_pkg::IDX_TOP_OF_STACK_HIGH, 8'h12);
      seq_op(psi_pkg::OP_RET, 11'h0, 8'h0);
      chk(pc_q, 15'h1234);
      rc(psi_pkg::IDX_STACK_POINTER, 8'h02);
   endtask

   task automatic t_regs();
      for (int i = 0; i < 8; i++) begin
         wr(psi_pkg::IDX_STATUS_SH + 12'(i), 8'(8'h11 * i + 8'h5));
      end
      for (int i = 0; i < 8; i++) begin
         rc(psi_pkg::IDX_STATUS_SH + 12'(i), 8'(8'h11 * i + 8'h5));
      end
      wr(12'h100, 8'haa);
      rc(12'h100, 8'h00);
   endtask

   task automatic t_ind();
      data_rdata <= 8'hc3;
      prog_rdata <= 14'h3d5a;
      indr(1'b0, 16'h0123, 8'h0, 8'hc3, 1'b0, 15'h0123, 0);
      indr(1'b0, 16'h2050, 8'h0, 8'hc3, 1'b0, 15'h00a0, 0);
      indr(1'b0, 16'h204f, 8'h0, 8'hc3, 1'b0, 15'h006f, 0);
      indr(1'b1, 16'h2000, 8'h3c, 8'h0, 1'b1, 15'h0020, 0);
      indr(1'b0, 16'h0000, 8'h0, 8'h00, 1'b0, 15'h7fff, 0);
      indr(1'b1, 16'h0001, 8'h99, 8'h0, 1'b0, 15'h7fff, 0);
      indr(1'b0, 16'h1800, 8'h0, 8'h00, 1'b0, 15'h7fff, 0);
      indr(1'b0, 16'h29b0, 8'h0, 8'h00, 1'b0, 15'h7fff, 0);
      indr(1'b0, 16'h8abc, 8'h0, 8'h5a, 1'b0, 15'h0abc, 1);
      indr(1'b1, 16'h8001, 8'h77, 8'h0, 1'b0, 15'h7fff, -1);
   endtask

   // Second reset in mid-run, stack pointer left away from its reset value
   task automatic t_rst2();
      @(posedge hclk);
      hresetn <= 1'b0;
      #1 chk(pc_q, 15'h0);
      @(posedge hclk);
      hresetn <= 1'b1;
      rc(psi_pkg::IDX_STACK_POINTER, 8'h1f);
   endtask

   initial begin
      t_reset();
      t_flow();
      t_stack();
      t_regs();
      t_ind();
      t_rst2();
      test_done();
   end
endmodule
`default_nettype wire
